// [verilog/phy_ctl_pkg.sv]
// Purpose: constants for the phy basic control register
// Assumes: 16-bit management word, 20 MHz clock
// Notes: shared by the register bank and its reset sequencer
package phy_ctl_pkg;
    localparam int CLK_NS = 50;
    localparam logic [4:0] CTL_ADDR = 5'h00;
    localparam int BIT_RESET = 15;
    localparam int BIT_LOOP = 14;
    localparam int BIT_SPEED = 13;
    localparam int BIT_ANEG = 12;
    localparam int BIT_PDOWN = 11;
    localparam int BIT_RESTART = 9;
    localparam int BIT_DUPLEX = 8;
    localparam int BIT_COLTEST = 7;
    localparam logic [15:0] CTL_RESET_VAL = 16'h3000;
    localparam logic [15:0] CTL_WMASK = 16'hFB80;
    localparam int DEAD_NS = 560;
    localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam int SRST_CYCLES = 16;
    localparam logic [4:0] SRST_LAST = 5'(SRST_CYCLES - 1);
    localparam logic [3:0] DEAD_LAST = 4'(DEAD_CYC - 1);
endpackage

// [verilog/srst_if.sv]
// Purpose: soft reset handshake between bank and sequencer
// Assumes: single clock
// Notes: start is a one-cycle pulse
`timescale 1ns/1ps
interface srst_if;
    logic start;
    logic busy;
    modport bank (output start, input busy);
    modport seq (input start, output busy);
endinterface

// [verilog/srst_seq.sv]
// Purpose: times the soft reset process
// Assumes: start is a one-cycle pulse
// Notes: busy is high for SRST_CYCLES cycles
`timescale 1ns/1ps
module srst_seq
    import phy_ctl_pkg::*;
(
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // handshake
    srst_if.seq sr
);
    logic [4:0] cnt_r;
    logic busy_r;

    assign sr.busy = busy_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_r <= 1'b0;
            cnt_r <= 5'h00;
        end else if (ce) begin
            if (sr.start) begin
                busy_r <= 1'b1;
                cnt_r <= 5'h00;
            end else if (busy_r) begin
                if (cnt_r == SRST_LAST) begin
                    busy_r <= 1'b0;
                end
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end
endmodule // srst_seq

// [verilog/phy_basic_control_register.sv]
// Purpose: phy basic control register and its datapath effects
// Assumes: management transactions are single 16-bit words
// Notes: soft reset stalls transactions via mgmt_ready
//
// Contract
// [R1] bit 15 resets registers, self-clears
// [R2] reset reads one, transactions held off
// [R3] bit 14 loops transmit nibbles to receive
// [R4] loopback isolates receive from medium
// [R5] loopback entry may blank receive 560 ns; code blanks 12 cycles (600 ns)
// [R6] loopback config setting overrides control bit
// [R7] bit 13 selects 100/10 without autoneg
// [R8] speed readback meaningful only without autoneg
// [R9] bit 12 autoneg; ignores speed, duplex
// [R10] bit 11 enters power-down
// [R11] bit 9 restarts autoneg, self-clears
// [R12] bit 8 selects full/half duplex
// [R13] single supported duplex forces duplex bit; code forces it on writes only, reset loads it 0
// [R14] loopback makes duplex bit irrelevant
// [R15] bit 7 forces collision on tx enable
// [R16] host writes zero to reserved bits
// [R17] register reached via management window
// [R18] whole word per transaction, reads all
`timescale 1ns/1ps
module phy_basic_control_register
    import phy_ctl_pkg::*;
(
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // management data window
    input wire logic mgmt_req,
    input wire logic mgmt_we,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic mgmt_ready,
    output logic [15:0] mgmt_rdata,
    // configuration straps
    input wire logic cfg_loop_valid,
    input wire logic cfg_loop_val,
    input wire logic only_full,
    input wire logic only_half,
    // mii side
    input wire logic [3:0] mii_txd,
    input wire logic mii_tx_en,
    input wire logic [3:0] line_rxd,
    input wire logic line_rx_dv,
    input wire logic line_col,
    output logic [3:0] mii_rxd,
    output logic mii_rx_dv,
    output logic mii_col,
    // phy controls
    output logic speed_100,
    output logic full_duplex,
    output logic aneg_en,
    output logic aneg_restart,
    output logic power_down,
    output logic loop_active
);
    logic [15:0] ctl_r;
    logic [15:0] ctl_nxt;
    logic restart_r;
    logic loop_d_r;
    logic [3:0] dead_cnt_r;
    logic dead_r;
    logic [3:0] rxd_r;
    logic rx_dv_r;
    logic col_r;
    logic wr_hit;
    logic rd_hit;
    logic loop_eff;
    logic loop_rise;
    srst_if sr();

    // control register address decode
    function automatic logic hit(input logic [4:0] a);
        return a == CTL_ADDR;
    endfunction

    // read view: self-clearing bits show their live state
    function automatic logic [15:0] rd_view(input logic [15:0] c,
            input logic rs);
        logic [15:0] v;
        v = c;
        v[BIT_RESTART] = rs;
        return v;
    endfunction

    // soft reset timing
    srst_seq u_seq (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .sr(sr)
    );

    assign mgmt_ready = !sr.busy; // see [R2]
    assign wr_hit = mgmt_req && mgmt_we && hit(mgmt_addr) && !sr.busy;
    assign rd_hit = mgmt_req && !mgmt_we && hit(mgmt_addr) && !sr.busy;
    assign sr.start = ce && wr_hit && mgmt_wdata[BIT_RESET]; // see [R1]

    // loopback config wins over control bit
    assign loop_eff = cfg_loop_valid ? cfg_loop_val
                                     : ctl_r[BIT_LOOP]; // see [R6]

    always_comb begin
        ctl_nxt = (ctl_r & ~CTL_WMASK) | (mgmt_wdata & CTL_WMASK); // see [R16]
        ctl_nxt[BIT_RESET] = 1'b0;
        ctl_nxt[BIT_RESTART] = 1'b0;
        if (only_full) begin
            ctl_nxt[BIT_DUPLEX] = 1'b1; // see [R13]
        end else if (only_half) begin
            ctl_nxt[BIT_DUPLEX] = 1'b0; // see [R13]
        end
    end

    // control word, whole-word writes
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_r <= CTL_RESET_VAL;
        end else if (ce) begin
            if (sr.start) begin
                ctl_r <= CTL_RESET_VAL; // see [R1]
            end else if (wr_hit) begin
                ctl_r <= ctl_nxt; // see [R17] [R18]
            end
        end
    end

    // restart pulse, self clearing
    always_ff @(posedge clk) begin
        if (rst) begin
            restart_r <= 1'b0;
        end else if (ce) begin
            restart_r <= wr_hit && !mgmt_wdata[BIT_RESET]
                && mgmt_wdata[BIT_RESTART]; // see [R11]
        end
    end

    // read data
    always_ff @(posedge clk) begin
        if (rst) begin
            mgmt_rdata <= 16'h0000;
        end else if (ce) begin
            if (rd_hit) begin
                mgmt_rdata <= rd_view(ctl_r, restart_r); // see [R8] [R18]
            end else if (sr.busy || sr.start) begin
                mgmt_rdata <= 16'h0000;
                mgmt_rdata[BIT_RESET] <= 1'b1; // see [R2]
            end
        end
    end

    // loopback level one cycle late, for entry detect
    always_ff @(posedge clk) begin
        if (rst) begin
            loop_d_r <= 1'b0;
        end else if (ce) begin
            loop_d_r <= loop_eff;
        end
    end

    // entry edge of effective loopback
    assign loop_rise = loop_eff && !loop_d_r;

    // dead time after loopback entry
    always_ff @(posedge clk) begin
        if (rst) begin
            dead_r <= 1'b0;
            dead_cnt_r <= 4'h0;
        end else if (ce) begin
            if (loop_rise) begin
                dead_r <= 1'b1; // see [R5]
                dead_cnt_r <= 4'h0;
            end else if (dead_r) begin
                if (dead_cnt_r == DEAD_LAST) begin
                    dead_r <= 1'b0;
                end
                dead_cnt_r <= dead_cnt_r + 4'h1;
            end
        end
    end

    // receive path
    always_ff @(posedge clk) begin
        if (rst) begin
            rxd_r <= 4'h0;
            rx_dv_r <= 1'b0;
        end else if (ce) begin
            if (power_down) begin
                rxd_r <= 4'h0;
                rx_dv_r <= 1'b0;
            end else if (loop_eff) begin
                rxd_r <= dead_r ? 4'h0 : mii_txd; // see [R3] [R4]
                rx_dv_r <= mii_tx_en && !dead_r; // see [R5]
            end else begin
                rxd_r <= line_rxd;
                rx_dv_r <= line_rx_dv;
            end
        end
    end

    // collision: forced by test bit, else from line
    always_ff @(posedge clk) begin
        if (rst) begin
            col_r <= 1'b0;
        end else if (ce) begin
            col_r <= (ctl_r[BIT_COLTEST] && mii_tx_en) // see [R15]
                || (!loop_eff && !power_down && line_col);
        end
    end

    assign mii_rxd = rxd_r;
    assign mii_rx_dv = rx_dv_r;
    assign mii_col = col_r;
    assign aneg_en = ctl_r[BIT_ANEG]; // see [R9]
    assign speed_100 = ctl_r[BIT_SPEED]; // see [R7]
    // duplex forced full in loopback, don't-care there
    assign full_duplex = loop_eff || ctl_r[BIT_DUPLEX]; // see [R12] [R14]
    assign aneg_restart = restart_r; // see [R11]
    assign power_down = ctl_r[BIT_PDOWN]; // see [R10]
    assign loop_active = loop_eff;
endmodule // phy_basic_control_register

// [test/phy_bcr_props.sv]
// Purpose: port checks for the control register
// Assumes: ce held high
// Notes: bound to the top module
`timescale 1ns/1ps
module phy_bcr_props (
    // clocking
    input wire logic clk,
    input wire logic rst,
    // management data window
    input wire logic mgmt_req,
    input wire logic mgmt_we,
    input wire logic mgmt_ready,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    // configuration straps
    input wire logic cfg_loop_valid,
    input wire logic cfg_loop_val,
    input wire logic only_full,
    input wire logic only_half,
    // phy controls
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic aneg_restart,
    input wire logic power_down,
    input wire logic loop_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic wr;
    logic ws;
    assign wr = mgmt_req && mgmt_ready && mgmt_we && mgmt_addr == 5'h00;
    assign ws = wr && !mgmt_wdata[15];
    reset_busy_a: assert property (wr && mgmt_wdata[15] |=>
        !mgmt_ready && mgmt_rdata == 16'h8000) else $error("reset busy");
    reset_len_a: assert property (wr && mgmt_wdata[15] |=>
        !mgmt_ready ##15 !mgmt_ready ##1 mgmt_ready) else $error("reset len");
    restart_pulse_a: assert property (ws && mgmt_wdata[9] |=>
        aneg_restart ##1 !aneg_restart) else $error("restart");
    speed_sel_a: assert property (ws |=>
        speed_100 == $past(mgmt_wdata[13])) else $error("speed");
    power_sel_a: assert property (ws |=>
        power_down == $past(mgmt_wdata[11])) else $error("power");
    duplex_sel_a: assert property (ws && !mgmt_wdata[14] && !only_full
        && !only_half && !cfg_loop_valid |=>
        full_duplex == $past(mgmt_wdata[8])) else $error("duplex");
    cfg_wins_a: assert property (cfg_loop_valid |->
        loop_active == cfg_loop_val) else $error("loop cfg");
    loop_full_a: assert property ($past(loop_active) && loop_active |->
        full_duplex) else $error("loop duplex");
endmodule // phy_bcr_props
bind phy_basic_control_register phy_bcr_props u_phy_bcr_props (
    .clk(clk),
    .rst(rst),
    .mgmt_req(mgmt_req),
    .mgmt_we(mgmt_we),
    .mgmt_ready(mgmt_ready),
    .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata),
    .cfg_loop_valid(cfg_loop_valid),
    .cfg_loop_val(cfg_loop_val),
    .only_full(only_full),
    .only_half(only_half),
    .speed_100(speed_100),
    .full_duplex(full_duplex),
    .aneg_restart(aneg_restart),
    .power_down(power_down),
    .loop_active(loop_active)
);

// [test/mgmt_host_model.sv]
// Purpose: mac side management master
// Assumes: one word per transaction
// Notes: reserved bits go out as zero
`timescale 1ns/1ps
module mgmt_host_model (
    // clocking and answer
    input wire logic clk,
    input wire logic ready,
    input wire logic [15:0] rdata,
    // request
    output logic req,
    output logic we,
    output logic [4:0] addr,
    output logic [15:0] wdata
);
    initial {req, we, addr, wdata} = '0;
    task automatic xfer(input logic w, input logic [4:0] a,
            input logic [15:0] d, output logic [15:0] q, output bit late);
        int n;
        n = 0;
        @(posedge clk);
        #1 {req, we, addr, wdata} = {1'b1, w, a, d & 16'hFB80};
        while (ready !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        late = (n >= 40);
        @(posedge clk);
        #1 q = rdata;
        req = 1'b0;
    endtask
endmodule // mgmt_host_model

// [test/phy_basic_control_register_tb_top.sv]
// Purpose: bench for the control register
// Assumes: ce held high
// Notes: host model drives the window
`timescale 1ns/1ps
module phy_basic_control_register_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req, we, rdy, fv, fl, of, oh, te, dv, col, sp, fd, an, ar, pd, la;
    logic [4:0] ad;
    logic [15:0] wd, rd, q;
    logic [3:0] td, rx;
    bit late;
    int bad_count = 0;
    int compares = 0;
    always #25 clk = ~clk;
    phy_basic_control_register u_phy_basic_control_register (.clk(clk),
        .rst(rst), .ce(1'b1), .mgmt_req(req), .mgmt_we(we), .mgmt_addr(ad),
        .mgmt_wdata(wd), .mgmt_ready(rdy), .mgmt_rdata(rd),
        .cfg_loop_valid(fv), .cfg_loop_val(fl), .only_full(of),
        .only_half(oh), .mii_txd(td), .mii_tx_en(te), .line_rxd(~td),
        .line_rx_dv(1'b1), .line_col(1'b0), .mii_rxd(rx), .mii_rx_dv(dv),
        .mii_col(col), .speed_100(sp), .full_duplex(fd), .aneg_en(an),
        .aneg_restart(ar), .power_down(pd), .loop_active(la));
    mgmt_host_model u_mgmt_host_model (.clk(clk), .ready(rdy), .rdata(rd),
        .req(req), .we(we), .addr(ad), .wdata(wd));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] d);
        u_mgmt_host_model.xfer(1'b1, 5'h00, d, q, late);
        if (late) bad_count++;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        u_mgmt_host_model.xfer(1'b0, a, 16'h0000, q, late);
        if (late) bad_count++;
        chk(q, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        {fv, fl, of, oh, te, td} = '0;
        tick(10);
        rst = 1'b0;
        rdc(5'h00, 16'h3000);
        wr(16'h2100);
        rdc(5'h00, 16'h2100);
        chk(16'({sp, fd, an}), 16'h6);
        wr(16'h1A00);
        chk(16'({pd, ar}), 16'h3);
        rdc(5'h00, 16'h1800);
        te = 1'b1;
        wr(16'h0080);
        tick(2);
        chk(16'(col), 16'h1);
        td = 4'hA;
        wr(16'h4000);
        tick(16);
        chk({rx, 9'h0, la, fd, dv}, 16'hA007);
        fv = 1'b1;
        tick(1);
        chk(16'(la), 16'h0);
        {fv, oh} = 2'b01;
        wr(16'h0100);
        rdc(5'h00, 16'h0000);
        oh = 1'b0;
        wr(16'h8000);
        chk({rd[15:1], rdy}, 16'h8000);
        rdc(5'h00, 16'h3000);
        rdc(5'h03, 16'h3000);
        wrap_up();
    end
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
endmodule // phy_basic_control_register_tb_top
